//--- logic/txbcp_params.svh
// Constants of the transmit buffer command parser: register offsets,
// command word field positions, reset values and storage depths.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TXBCP_PARAMS_SVH
`define TXBCP_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TXBCP_ADDR_W 5
`define TXBCP_OFS_DATA 5'h00
`define TXBCP_OFS_STAT 5'h04
`define TXBCP_OFS_SPACE 5'h08
`define TXBCP_OFS_FLAGS 5'h0c
`define TXBCP_OFS_LEVEL 5'h10

// ****************************************
// Command word fields
// ****************************************
`define TXBCP_A_IOC 31
`define TXBCP_A_ALIGN_HI 25
`define TXBCP_A_ALIGN_LO 24
`define TXBCP_A_OFS_HI 20
`define TXBCP_A_OFS_LO 16
`define TXBCP_A_FIRST 13
`define TXBCP_A_LAST 12
`define TXBCP_A_SIZE_HI 10
`define TXBCP_B_TAG_HI 31
`define TXBCP_B_TAG_LO 16
`define TXBCP_B_LEN_HI 10
`define TXBCP_ALIGN_16 2'h1
`define TXBCP_ALIGN_32 2'h2

// ****************************************
// Flag bits, space word field, reset value and FIFO address widths
// ****************************************
`define TXBCP_FLAG_ERR 0
`define TXBCP_FLAG_DONE 1
`define TXBCP_FLAG_LEVEL 2
`define TXBCP_SPACE_CNT_LO 16
`define TXBCP_LEVEL_RST 4'h1
`define TXBCP_DFIFO_AW 4
`define TXBCP_SFIFO_AW 3

`endif

//--- logic/txbcp_pkg.sv
// Types shared by the transmit buffer command parser and its FIFO.
// Assumes the constants header is on the include path.
`include "txbcp_params.svh"

package txbcp_pkg;

	typedef enum logic [1:0] {PS_CMDA, PS_CMDB, PS_DATA} txbcp_state_t;

	// One stored data word: payload bytes marked in mask, plus packet status on the last one
	typedef struct packed {
		logic [15:0] tag;
		logic err;
		logic [10:0] cnt;
		logic last;
		logic [3:0] mask;
		logic [31:0] data;
	} txbcp_entry_t;

	localparam int TXBCP_ENTRY_W = $bits(txbcp_entry_t);

endpackage

//--- logic/txbcp_fifo.sv
// Synchronous flip-flop FIFO used for transmit data and transmit status.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module txbcp_fifo #(
	parameter int W = 32,
	parameter int AW = 3
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic push_i,
	input wire logic [W-1:0] push_data_i,
	input wire logic pop_i,
	output logic [W-1:0] head_o,
	output logic full_o,
	output logic empty_o,
	output logic [AW:0] count_o
);

	localparam int DEPTH = 1 << AW;

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic do_push, do_pop;

	always_comb begin
		// A push into a full FIFO is dropped; the caller reports it
		do_push = push_i && (cnt_r != DEPTH[AW:0]);
		do_pop = pop_i && (cnt_r != '0);
		wr_nxt = do_push ? wr_r + 1'b1 : wr_r;
		rd_nxt = do_pop ? rd_r + 1'b1 : rd_r;
		cnt_nxt = cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_r[wr_r] <= push_data_i;
		end
	end

	assign head_o = mem_r[rd_r];
	assign full_o = (cnt_r == DEPTH[AW:0]);
	assign empty_o = (cnt_r == '0);
	assign count_o = cnt_r;

endmodule

`default_nettype wire

//--- logic/txbcp_top.sv
// Transmit buffer command parser: takes buffers written over Avalon-MM,
// strips commands, offsets and padding, checks packet consistency and
// hands payload bytes to the transmitter; posts one status word per packet.
// Assumes the transmitter and bus master run on clk_i.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "txbcp_params.svh"

// Contract
// - Each buffer opens with command words A, B
// - Packet boundaries come only from command bits
// - Status word carries the tag from B
// - Differing tags within a packet raise error
// - Delivered byte count differing from length errors
// - Command B must match across packet buffers
// - Bytes before start offset are discarded
// - Later buffers may start on any byte
// - Accept padding words and never transmit them
// - Interrupt-on-completion bit sets buffer loaded flag
// - Push status word after each packet ends
// - Flag when status count reaches programmed level
// - Overfilling the data FIFO raises error
// - Start offset is A bits 20:16
// - A bit 13 first, bit 12 last segment
module txbcp_top
	import txbcp_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [`TXBCP_ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	output logic transmit_error_flag_o,
	output logic buffer_loaded_flag_o,
	output logic stat_level_o
);

	// ****************************************
	// Helpers
	// ****************************************
	// Data words the buffer occupies after command B, padding included
	function automatic logic [9:0] buf_words(input logic [31:0] a);
		logic [11:0] fin;
		logic [11:0] rnd;
		fin = {7'h00, a[`TXBCP_A_OFS_HI:`TXBCP_A_OFS_LO]} + {1'b0, a[`TXBCP_A_SIZE_HI:0]};
		case (a[`TXBCP_A_ALIGN_HI:`TXBCP_A_ALIGN_LO])
			`TXBCP_ALIGN_16: rnd = (fin + 12'h00f) & 12'hff0;
			`TXBCP_ALIGN_32: rnd = (fin + 12'h01f) & 12'hfe0;
			default: rnd = (fin + 12'h003) & 12'hffc;
		endcase
		return rnd[11:2];
	endfunction

	function automatic logic more_above(input logic [3:0] m, input logic [1:0] s);
		return (m >> ({1'b0, s} + 3'h1)) != 4'h0;
	endfunction

	// ****************************************
	// Bus slave
	// ****************************************
	logic wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt, done_r, done_nxt, lvl_r, lvl_nxt;
	logic [3:0] level_r, level_nxt;
	logic take, data_wr, flag_clr, spop;
	logic err_ev, done_ev, ovf_ev, sovf_ev;
	logic [`TXBCP_DFIFO_AW:0] dcount;
	logic [`TXBCP_SFIFO_AW:0] scount;
	logic [31:0] shead;
	logic sempty, sfull;

	always_comb begin
		take = (read_i || write_i) && !wait_r;
		// One wait cycle on every access, then a single ready cycle
		wait_nxt = !((read_i || write_i) && wait_r);
		data_wr = write_i && take && (address_i == `TXBCP_OFS_DATA);
		flag_clr = write_i && take && (address_i == `TXBCP_OFS_FLAGS) && byteenable_i[0];
		spop = read_i && take && (address_i == `TXBCP_OFS_STAT) && !sempty;
		rdata_nxt = rdata_r;
		if (read_i && wait_r) begin
			if (address_i == `TXBCP_OFS_STAT) begin
				rdata_nxt = sempty ? 32'h0000_0000 : shead;
			end else if (address_i == `TXBCP_OFS_SPACE) begin
				rdata_nxt = '0;
				rdata_nxt[`TXBCP_DFIFO_AW:0] = (5'h10 - dcount);
				rdata_nxt[`TXBCP_SPACE_CNT_LO +: `TXBCP_SFIFO_AW+1] = scount;
			end else if (address_i == `TXBCP_OFS_FLAGS) begin
				rdata_nxt = '0;
				rdata_nxt[`TXBCP_FLAG_ERR] = err_r;
				rdata_nxt[`TXBCP_FLAG_DONE] = done_r;
				rdata_nxt[`TXBCP_FLAG_LEVEL] = lvl_r;
			end else if (address_i == `TXBCP_OFS_LEVEL) begin
				rdata_nxt = {28'h0000000, level_r};
			end else begin
				rdata_nxt = 32'h0000_0000;
			end
		end
		level_nxt = level_r;
		if (write_i && take && (address_i == `TXBCP_OFS_LEVEL) && byteenable_i[0]) begin
			level_nxt = writedata_i[3:0];
		end
		// Write one to clear; a new event in the same cycle keeps the flag set
		err_nxt = (err_r && !(flag_clr && writedata_i[`TXBCP_FLAG_ERR])) || err_ev;
		done_nxt = (done_r && !(flag_clr && writedata_i[`TXBCP_FLAG_DONE])) || done_ev;
		lvl_nxt = ({1'b0, scount} >= {1'b0, level_r});
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_r <= 1'b1;
			rdata_r <= '0;
			err_r <= 1'b0;
			done_r <= 1'b0;
			lvl_r <= 1'b0;
			level_r <= `TXBCP_LEVEL_RST;
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
			done_r <= done_nxt;
			lvl_r <= lvl_nxt;
			level_r <= level_nxt;
		end
	end

	// ****************************************
	// Command parser
	// ****************************************
	txbcp_state_t state_r, state_nxt;
	logic [31:0] cmda_r, cmda_nxt, pktb_r, pktb_nxt;
	logic in_pkt_r, in_pkt_nxt, perr_r, perr_nxt, hit_r, hit_nxt;
	logic [10:0] cnt_r, cnt_nxt;
	logic [11:0] pos_r, pos_nxt;
	logic [9:0] words_r, words_nxt;
	txbcp_entry_t ent, dhead;
	logic dpush, dfull, dempty, dpop;
	logic buf_end, bad, hit, lastseg;
	logic [10:0] c, len;
	logic [11:0] p, lo, hi;

	always_comb begin
		state_nxt = state_r;
		cmda_nxt = cmda_r;
		pktb_nxt = pktb_r;
		in_pkt_nxt = in_pkt_r;
		perr_nxt = perr_r;
		hit_nxt = hit_r;
		cnt_nxt = cnt_r;
		pos_nxt = pos_r;
		words_nxt = words_r;
		ent = '0;
		dpush = 1'b0;
		done_ev = 1'b0;
		ovf_ev = 1'b0;
		buf_end = 1'b0;
		bad = 1'b0;
		hit = hit_r;
		c = cnt_r;
		p = '0;
		len = pktb_r[`TXBCP_B_LEN_HI:0];
		lastseg = cmda_r[`TXBCP_A_LAST];
		lo = {7'h00, cmda_r[`TXBCP_A_OFS_HI:`TXBCP_A_OFS_LO]};
		hi = lo + {1'b0, cmda_r[`TXBCP_A_SIZE_HI:0]};
		if (data_wr) begin
			case (state_r)
				PS_CMDA: begin
					cmda_nxt = writedata_i;
					state_nxt = PS_CMDB;
				end
				PS_CMDB: begin
					words_nxt = buf_words(cmda_r);
					pos_nxt = '0;
					state_nxt = PS_DATA;
					if (cmda_r[`TXBCP_A_FIRST]) begin
						bad = in_pkt_r;
						pktb_nxt = writedata_i;
						in_pkt_nxt = 1'b1;
						c = '0;
						hit = 1'b0;
					end else if (!in_pkt_r || (writedata_i != pktb_r)) begin
						bad = 1'b1;
					end
					buf_end = (buf_words(cmda_r) == 10'h000);
				end
				default: begin
					for (int j = 0; j < 4; j++) begin
						p = pos_r + 12'(j);
						// Offset bytes and padding fall outside lo..hi
						if ((p >= lo) && (p < hi)) begin
							if (hit || (c == len)) begin
								bad = 1'b1;
							end else begin
								ent.mask[j] = 1'b1;
								c = c + 11'h001;
								if (lastseg && (c == len)) begin
									hit = 1'b1;
									ent.last = 1'b1;
								end
							end
						end
					end
					pos_nxt = pos_r + 12'h004;
					words_nxt = words_r - 10'h001;
					buf_end = (words_r == 10'h001);
				end
			endcase
			len = pktb_nxt[`TXBCP_B_LEN_HI:0];
			if (buf_end) begin
				state_nxt = PS_CMDA;
				done_ev = cmda_r[`TXBCP_A_IOC];
				if (lastseg) begin
					bad = bad || (c != len) || !in_pkt_nxt;
					// A short packet still closes, possibly with an empty word
					ent.last = ent.last || (!hit && in_pkt_nxt);
					in_pkt_nxt = 1'b0;
					hit = 1'b1;
				end
			end
			ent.data = writedata_i;
			ent.cnt = c;
			ent.err = perr_r || bad;
			ent.tag = pktb_nxt[`TXBCP_B_TAG_HI:`TXBCP_B_TAG_LO];
			dpush = (state_r == PS_DATA || buf_end) && ((ent.mask != 4'h0) || ent.last);
			ovf_ev = dpush && dfull;
			perr_nxt = (state_r == PS_CMDB && cmda_r[`TXBCP_A_FIRST]) ? 1'b0 : perr_r;
			perr_nxt = perr_nxt || bad || ovf_ev;
			cnt_nxt = c;
			hit_nxt = hit;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= PS_CMDA;
			cmda_r <= '0;
			pktb_r <= '0;
			in_pkt_r <= 1'b0;
			perr_r <= 1'b0;
			hit_r <= 1'b0;
			cnt_r <= '0;
			pos_r <= '0;
			words_r <= '0;
		end else begin
			state_r <= state_nxt;
			cmda_r <= cmda_nxt;
			pktb_r <= pktb_nxt;
			in_pkt_r <= in_pkt_nxt;
			perr_r <= perr_nxt;
			hit_r <= hit_nxt;
			cnt_r <= cnt_nxt;
			pos_r <= pos_nxt;
			words_r <= words_nxt;
		end
	end

	assign err_ev = (data_wr && (bad || ovf_ev)) || sovf_ev;

	txbcp_fifo #(.W(TXBCP_ENTRY_W), .AW(`TXBCP_DFIFO_AW)) u_data_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.push_i(dpush),
		.push_data_i(ent),
		.pop_i(dpop),
		.head_o(dhead),
		.full_o(dfull),
		.empty_o(dempty),
		.count_o(dcount)
	);

	// ****************************************
	// Byte unpacker and status posting
	// ****************************************
	logic [1:0] sel_r, sel_nxt;
	logic txv_r, txv_nxt, txl_r, txl_nxt;
	logic [7:0] txd_r, txd_nxt;
	logic [31:0] spend_r, spend_nxt, sword;
	logic spush;

	always_comb begin
		sel_nxt = sel_r;
		txv_nxt = txv_r;
		txl_nxt = txl_r;
		txd_nxt = txd_r;
		spend_nxt = spend_r;
		dpop = 1'b0;
		spush = 1'b0;
		sword = {dhead.tag, dhead.err, 4'h0, dhead.cnt};
		if (txv_r && tx_ready_i) begin
			txv_nxt = 1'b0;
			txl_nxt = 1'b0;
			spush = txl_r;
		end
		if ((!txv_r || tx_ready_i) && !dempty) begin
			if (dhead.mask == 4'h0) begin
				// Status-only word; waits until the output stage is idle
				if (!txv_r) begin
					dpop = 1'b1;
					sel_nxt = 2'h0;
					spush = 1'b1;
					spend_nxt = sword;
				end
			end else begin
				if (dhead.mask[sel_r]) begin
					txv_nxt = 1'b1;
					txd_nxt = dhead.data[{sel_r, 3'b000} +: 8];
					txl_nxt = dhead.last && !more_above(dhead.mask, sel_r);
					if (txl_nxt) begin
						spend_nxt = sword;
					end
				end
				if ((sel_r == 2'h3) || !more_above(dhead.mask, sel_r)) begin
					dpop = 1'b1;
					sel_nxt = 2'h0;
				end else begin
					sel_nxt = sel_r + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_r <= '0;
			txv_r <= 1'b0;
			txl_r <= 1'b0;
			txd_r <= '0;
			spend_r <= '0;
		end else begin
			sel_r <= sel_nxt;
			txv_r <= txv_nxt;
			txl_r <= txl_nxt;
			txd_r <= txd_nxt;
			spend_r <= spend_nxt;
		end
	end

	assign sovf_ev = spush && sfull;

	txbcp_fifo #(.W(32), .AW(`TXBCP_SFIFO_AW)) u_stat_fifo (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.push_i(spush),
		.push_data_i(dpop && (dhead.mask == 4'h0) ? sword : spend_r),
		.pop_i(spop),
		.head_o(shead),
		.full_o(sfull),
		.empty_o(sempty),
		.count_o(scount)
	);

	assign readdata_o = rdata_r;
	assign waitrequest_o = wait_r;
	assign tx_data_o = txd_r;
	assign tx_valid_o = txv_r;
	assign tx_last_o = txl_r;
	assign transmit_error_flag_o = err_r;
	assign buffer_loaded_flag_o = done_r;
	assign stat_level_o = lvl_r;

endmodule

`default_nettype wire

//--- testbench/txbcp_top_props.sv
// Checker for the transmit buffer command parser, bound to its top module.
// Assumes one clock domain and the register offsets of the constants header.
`timescale 1ns/1ns
`default_nettype none
`include "txbcp_params.svh"

module txbcp_props
	import txbcp_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [`TXBCP_ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_last_o,
	input wire logic tx_ready_i,
	input wire logic transmit_error_flag_o,
	input wire logic buffer_loaded_flag_o,
	input wire logic stat_level_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic req, unmapped, clr_flags;
	assign req = read_i | write_i;
	assign unmapped = address_i > `TXBCP_OFS_LEVEL || address_i[1:0] != 2'h0;
	assign clr_flags = write_i && !waitrequest_o && address_i == `TXBCP_OFS_FLAGS
		&& byteenable_i[0];
	sequence bus_take;
		req && !waitrequest_o;
	endsequence
	sequence tx_stall;
		tx_valid_o && !tx_ready_i;
	endsequence

	wait_one_a: assert property ($rose(req) |=> !waitrequest_o)
		else $error("request not answered after one wait cycle");
	wait_pulse_a: assert property (bus_take |=> waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	idle_wait_a: assert property (!req |=> waitrequest_o)
		else $error("waitrequest low without a request");
	tx_hold_a: assert property (tx_stall |=> tx_valid_o && $stable(tx_data_o)
		&& $stable(tx_last_o))
		else $error("offered byte changed before it was taken");
	last_valid_a: assert property (tx_last_o |-> tx_valid_o)
		else $error("packet end marker without a valid byte");
	err_sticky_a: assert property (transmit_error_flag_o && !(clr_flags && writedata_i[0])
		|=> transmit_error_flag_o)
		else $error("error flag dropped without a clear");
	done_sticky_a: assert property (buffer_loaded_flag_o && !(clr_flags && writedata_i[1])
		|=> buffer_loaded_flag_o)
		else $error("buffer loaded flag dropped without a clear");
	unmapped_zero_a: assert property (bus_take ##0 (read_i && unmapped)
		|-> readdata_o == 32'h0)
		else $error("unmapped read returned nonzero data");
endmodule

bind txbcp_top txbcp_props u_props (.clk_i(clk_i), .resetn_i(resetn_i),
	.address_i(address_i), .read_i(read_i), .write_i(write_i),
	.byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
	.tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
	.transmit_error_flag_o(transmit_error_flag_o),
	.buffer_loaded_flag_o(buffer_loaded_flag_o), .stat_level_o(stat_level_o));
`default_nettype wire

//--- testbench/txbcp_host.sv
// Host model: Avalon-MM master that writes command and payload buffers.
// Assumes the slave answers by pulling waitrequest low; a hang raises timeout_o.
`timescale 1ns/1ns
`default_nettype none
`include "txbcp_params.svh"

module txbcp_host
	import txbcp_pkg::*;
(
	input wire logic clk_i,
	input wire logic waitrequest_i,
	input wire logic [31:0] readdata_i,
	output logic [`TXBCP_ADDR_W-1:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [3:0] byteenable_o,
	output logic [31:0] writedata_o,
	output logic timeout_o
);
	initial begin
		{address_o, read_o, write_o, writedata_o, timeout_o} = '0;
		byteenable_o = 4'h1;
	end

	task automatic acc(input logic rd, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_i);
		address_o <= a;
		read_o <= rd;
		write_o <= !rd;
		writedata_o <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_i !== 1'b0 && n < 50);
		q = readdata_i;
		if (n >= 50)
			timeout_o = 1'b1;
		read_o <= 1'b0;
		write_o <= 1'b0;
		// Released lines flip so stale values cannot pass for live ones
		writedata_o <= ~d;
		address_o <= ~a;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		acc(1'b1, a, 32'h0, q);
	endtask

	// Payload byte i of the buffer is seed + i; padding slots carry 8'hee
	task automatic put_buf(input logic [31:0] a, input logic [31:0] b, input logic [7:0] seed);
		logic [31:0] w, q;
		int ofs, sz, al, nw, p;
		ofs = a[20:16];
		sz = a[10:0];
		al = (a[25:24] == 2'h1) ? 16 : (a[25:24] == 2'h2) ? 32 : 4;
		nw = (ofs + sz + al - 1) / al * al / 4;
		rd(`TXBCP_OFS_SPACE, q);
		wr(`TXBCP_OFS_DATA, a & 32'h83ff_ffff);
		wr(`TXBCP_OFS_DATA, b);
		for (int k = 0; k < nw; k++) begin
			for (int n = 0; n < 4; n++) begin
				p = 4 * k + n;
				w[8*n +: 8] = (p >= ofs && p < ofs + sz) ? seed + 8'(p - ofs) : 8'hee;
			end
			wr(`TXBCP_OFS_DATA, w);
		end
	endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the transmit buffer command parser.
// Assumes the host model drives the register bus; the byte sink lives here.
`timescale 1ns/1ns
`default_nettype none
`include "txbcp_params.svh"

module tb;
	import txbcp_pkg::*;
	logic clk_i, resetn_i, read_i, write_i, waitrequest_o, tx_valid_o, tx_last_o;
	logic tx_ready_i, transmit_error_flag_o, buffer_loaded_flag_o, stat_level_o, host_to;
	logic [4:0] address_i;
	logic [3:0] byteenable_i;
	logic [31:0] writedata_i, readdata_o, q;
	logic [7:0] tx_data_o;
	logic [7:0] got_d[$];
	logic got_l[$];
	int err_total, checks, sink_mode;

	txbcp_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .byteenable_i(byteenable_i),
		.writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
		.tx_ready_i(tx_ready_i), .transmit_error_flag_o(transmit_error_flag_o),
		.buffer_loaded_flag_o(buffer_loaded_flag_o), .stat_level_o(stat_level_o));
	txbcp_host u_host (.clk_i(clk_i), .waitrequest_i(waitrequest_o),
		.readdata_i(readdata_o), .address_o(address_i), .read_o(read_i),
		.write_o(write_i), .byteenable_o(byteenable_i), .writedata_o(writedata_i),
		.timeout_o(host_to));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Sink: mode 0 always ready, 1 alternating stall, 2 fully stalled
	always @(posedge clk_i) begin
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
			got_d.push_back(tx_data_o);
			got_l.push_back(tx_last_o);
		end
		tx_ready_i <= (sink_mode == 2) ? 1'b0 : (sink_mode == 1) ? ~tx_ready_i : 1'b1;
	end

	always @(posedge host_to) begin
		err_total++;
		report_and_stop();
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic expect_pkt(input int n, input logic [7:0] seed);
		int t;
		t = 0;
		while (got_d.size() < n && t < 2000) begin
			@(posedge clk_i);
			t++;
		end
		if (t >= 2000) begin
			err_total++;
			report_and_stop();
		end
		repeat (4) @(posedge clk_i);
		chk(got_d.size(), n);
		for (int i = 0; i < n; i++) begin
			chk(got_d[i], seed + 8'(i));
			chk(got_l[i], i == n - 1);
		end
	endtask

	task automatic drain();
		repeat (60) @(posedge clk_i);
		got_d.delete();
		got_l.delete();
	endtask

	task automatic s_regs();
		u_host.rd(`TXBCP_OFS_LEVEL, q);
		chk(q[3:0], 4'h1);
		u_host.wr(`TXBCP_OFS_LEVEL, 32'h3);
		u_host.rd(`TXBCP_OFS_LEVEL, q);
		chk(q, 32'h3);
		u_host.wr(`TXBCP_OFS_LEVEL, 32'h1);
		u_host.rd(5'h14, q);
		chk(q, 32'h0);
		u_host.rd(`TXBCP_OFS_SPACE, q);
		chk(q & 32'h000f_001f, 32'h10);
		chk(stat_level_o, 1'b0);
	endtask

	task automatic s_single();
		u_host.put_buf(32'h0103_3009, 32'h1234_0009, 8'h10);
		expect_pkt(9, 8'h10);
		chk(stat_level_o, 1'b1);
		u_host.rd(`TXBCP_OFS_STAT, q);
		chk(q, 32'h1234_0009);
		chk(transmit_error_flag_o, 1'b0);
		repeat (3) @(posedge clk_i);
		chk(stat_level_o, 1'b0);
		drain();
	endtask

	task automatic s_split();
		sink_mode = 1;
		u_host.put_buf(32'h0200_2005, 32'h5a5a_0009, 8'h40);
		chk(buffer_loaded_flag_o, 1'b0);
		u_host.put_buf(32'h8006_1004, 32'h5a5a_0009, 8'h45);
		expect_pkt(9, 8'h40);
		chk(buffer_loaded_flag_o, 1'b1);
		chk(transmit_error_flag_o, 1'b0);
		u_host.rd(`TXBCP_OFS_STAT, q);
		chk(q, 32'h5a5a_0009);
		u_host.wr(`TXBCP_OFS_FLAGS, 32'h2);
		@(posedge clk_i);
		chk(buffer_loaded_flag_o, 1'b0);
		sink_mode = 0;
		drain();
	endtask

	task automatic s_tagdiff();
		u_host.put_buf(32'h0000_2004, 32'h1111_0008, 8'h60);
		u_host.put_buf(32'h0000_1004, 32'h2222_0008, 8'h64);
		drain();
		chk(transmit_error_flag_o, 1'b1);
		u_host.rd(`TXBCP_OFS_STAT, q);
		chk(q[31:15], {16'h1111, 1'b1});
		u_host.wr(`TXBCP_OFS_FLAGS, 32'h1);
		@(posedge clk_i);
		chk(transmit_error_flag_o, 1'b0);
	endtask

	task automatic s_short();
		u_host.put_buf(32'h0000_3006, 32'h7777_000a, 8'h80);
		expect_pkt(6, 8'h80);
		u_host.rd(`TXBCP_OFS_STAT, q);
		chk(q, 32'h7777_8006);
		chk(transmit_error_flag_o, 1'b1);
		u_host.wr(`TXBCP_OFS_FLAGS, 32'h1);
		@(posedge clk_i);
		chk(transmit_error_flag_o, 1'b0);
		drain();
	endtask

	task automatic s_over();
		sink_mode = 2;
		u_host.put_buf(32'h0000_3050, 32'h0001_0050, 8'h00);
		chk(transmit_error_flag_o, 1'b1);
		sink_mode = 0;
		drain();
	endtask

	initial begin
		resetn_i = 1'b0;
		tx_ready_i = 1'b0;
		sink_mode = 0;
		err_total = 0;
		checks = 0;
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		s_regs();
		s_single();
		s_split();
		s_tagdiff();
		s_short();
		s_over();
		report_and_stop();
	end
endmodule
`default_nettype wire
